// *** include/cdsx_pkg.sv ***
package cdsx_pkg;

  // ****************************************************************
  // Instruction encoding
  // ****************************************************************
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [13:0] WORD_RESET = 14'h0000;

  // ****************************************************************
  // Phase timing
  // ****************************************************************
  localparam int PHASE_COUNT = 4;

  typedef enum logic [1:0] {
    CDSX_OP_NONE,
    CDSX_OP_COMPLEMENT,
    CDSX_OP_DEC_SKIP
  } cdsx_op_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } cdsx_file_wr_t;

  typedef struct packed {
    logic zero_we;
    logic zero_val;
  } cdsx_flag_t;

endpackage

// *** rtl/cdsx_phase_gen.sv ***
`timescale 1ns/1ps
module cdsx_phase_gen
  import cdsx_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic arst_n, // Async reset, active low
  output logic [3:0] phase_q // One-hot Q1..Q4
);
  import cdsx_pkg::*;

  // ****************************************************************
  // Four-phase rotator
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q <= 4'h1;
    end
    else
    begin
      phase_q <= {phase_q[PHASE_COUNT-2:0], phase_q[PHASE_COUNT-1]};
    end
  end

endmodule // cdsx_phase_gen

// *** rtl/cdsx_exec.sv ***
// Contract
// - Complement opcode inverts addressed register and updates zero flag.
// - Complement: d=0 writes accumulator, d=1 writes back to register.
// - Complement takes one cycle: decode Q1, read Q2, process Q3, write Q4.
// - Decrement-skip subtracts one from register; status flags untouched.
// - Decrement-skip: d=0 writes accumulator, d=1 writes back to register.
// - Zero result discards fetched next instruction, runs no-operation instead.
// - Nonzero result runs next instruction normally, single cycle.
// - Decrement-skip phases Q1..Q4; on skip a second no-operation cycle follows.
`timescale 1ns/1ps
module cdsx_exec
  import cdsx_pkg::*;
(
  input wire logic ref_clk, // Core clock, 40 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [13:0] instr_word, // Fetched word, sampled in Q1
  output logic [6:0] rd_addr, // Register file read address
  input wire logic [7:0] rd_data, // Register file read data, same clock
  output cdsx_pkg::cdsx_file_wr_t file_wr, // Write address and data
  output logic file_we, // Register write strobe, Q4 pulse
  output logic [7:0] acc_q, // Working accumulator
  output cdsx_pkg::cdsx_flag_t zero_flag, // Zero flag update, Q4 pulse
  output logic no_operation, // High while the cycle is a no-operation
  output logic [3:0] phase // Current phase, one-hot Q1..Q4
);
  import cdsx_pkg::*;

  cdsx_op_t op_reg;
  logic dest_reg;
  logic [7:0] opnd_reg;
  logic [7:0] result_reg;
  logic skip_reg;
  logic nop_reg;
  logic [6:0] addr_reg;
  logic q1, q2, q3, q4;

  cdsx_phase_gen u_phase
  (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .phase_q(phase)
  );

  assign q1 = phase[0];
  assign q2 = phase[1];
  assign q3 = phase[2];
  assign q4 = phase[3];
  assign rd_addr = addr_reg;
  assign no_operation = nop_reg;

  function automatic cdsx_op_t decode_op(input logic [13:0] w);
    case (w[OPC_HI:OPC_LO])
      OPC_COMPLEMENT: decode_op = CDSX_OP_COMPLEMENT;
      OPC_DEC_SKIP: decode_op = CDSX_OP_DEC_SKIP;
      default: decode_op = CDSX_OP_NONE;
    endcase
  endfunction

  // ****************************************************************
  // Q1 decode; a pending skip turns this cycle into a no-operation
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_reg <= CDSX_OP_NONE;
      dest_reg <= DEST_ACC;
      addr_reg <= '0;
      nop_reg <= 1'b0;
    end
    else if (q1)
    begin
      nop_reg <= skip_reg;
      if (skip_reg)
      begin
        op_reg <= CDSX_OP_NONE;
      end
      else
      begin
        op_reg <= decode_op(instr_word);
      end
      dest_reg <= instr_word[DEST_BIT];
      addr_reg <= instr_word[ADDR_W-1:0];
    end
  end

  // ****************************************************************
  // Q2 read, Q3 process
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opnd_reg <= DATA_RESET;
      result_reg <= DATA_RESET;
    end
    else if (q2)
    begin
      opnd_reg <= rd_data;
    end
    else if (q3)
    begin
      case (op_reg)
        CDSX_OP_COMPLEMENT: result_reg <= ~opnd_reg;
        CDSX_OP_DEC_SKIP: result_reg <= opnd_reg - 8'h01;
        default: result_reg <= opnd_reg;
      endcase
    end
  end

  // ****************************************************************
  // Q4 write destination
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= DATA_RESET;
      file_we <= 1'b0;
      file_wr <= '0;
      zero_flag <= '0;
    end
    else
    begin
      file_we <= 1'b0;
      zero_flag <= '0;
      if (q4 && op_reg != CDSX_OP_NONE)
      begin
        if (dest_reg == DEST_FILE)
        begin
          file_we <= 1'b1;
          file_wr.addr <= addr_reg;
          file_wr.data <= result_reg;
        end
        else
        begin
          acc_q <= result_reg;
        end
        if (op_reg == CDSX_OP_COMPLEMENT)
        begin
          zero_flag.zero_we <= 1'b1;
          zero_flag.zero_val <= (result_reg == DATA_RESET);
        end
      end
    end
  end

  // Skip is decided on the result and consumed at the next Q1
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skip_reg <= 1'b0;
    end
    else if (q4)
    begin
      skip_reg <= (op_reg == CDSX_OP_DEC_SKIP) && (result_reg == DATA_RESET);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_COMP_RESULT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_COMPLEMENT) |-> result_reg == ~opnd_reg)
    else $error("complement result wrong");
  AST_COMP_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_COMPLEMENT) |=> zero_flag.zero_we &&
      zero_flag.zero_val == ($past(result_reg) == 8'h00))
    else $error("zero flag not updated");
  AST_COMP_DEST: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_COMPLEMENT && dest_reg) |=> file_we && file_wr.data == $past(result_reg))
    else $error("complement write-back missing");
  AST_WE_PHASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    file_we |-> q1 && $past(q4))
    else $error("write outside Q4");
  AST_DEC_NOFLAG: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP) |=> !zero_flag.zero_we)
    else $error("decrement touched flag");
  AST_DEC_ACC: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP && !dest_reg) |=> acc_q == $past(opnd_reg) - 8'h01 && !file_we)
    else $error("decrement accumulator wrong");
  AST_SKIP_NOP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP && result_reg == 8'h00) |=> ##1 nop_reg && op_reg == CDSX_OP_NONE)
    else $error("skip did not insert no-operation");
  AST_NOSKIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP && result_reg != 8'h00) |=> ##1 !nop_reg)
    else $error("spurious skip");
  AST_SKIP_LEN: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q1 && skip_reg) |=> nop_reg [*4])
    else $error("no-operation cycle too short");
  AST_DEC_RESULT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP) |-> result_reg == opnd_reg - 8'h01)
    else $error("decrement result wrong");
  AST_DEC_DEST: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_DEC_SKIP && dest_reg) |=> file_we &&
      file_wr.addr == $past(addr_reg) && file_wr.data == $past(result_reg))
    else $error("decrement write-back missing");
  AST_COMP_ACC: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_COMPLEMENT && !dest_reg) |=> acc_q == $past(result_reg) && !file_we)
    else $error("complement accumulator wrong");
  AST_FILE_KEEPS_ACC: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg != CDSX_OP_NONE && dest_reg) |=> $stable(acc_q))
    else $error("register write disturbed accumulator");
  AST_ACC_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!q4) |=> $stable(acc_q))
    else $error("accumulator changed outside Q4");
  AST_FLAG_PHASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    zero_flag.zero_we |-> q1 && $past(q4))
    else $error("flag update outside Q4");
  AST_COMP_NOSKIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_COMPLEMENT) |=> ##1 !nop_reg)
    else $error("complement caused a skip");
  // A discarded word must leave neither a write nor a flag update behind
  AST_NOP_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q4 && op_reg == CDSX_OP_NONE) |=> !file_we && !zero_flag.zero_we)
    else $error("no-operation slot had an effect");
  AST_SKIP_DROP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q1 && skip_reg) |=> op_reg == CDSX_OP_NONE && nop_reg)
    else $error("fetched word not discarded");
  AST_NOP_END: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q1 && skip_reg) |=> ##4 !nop_reg)
    else $error("no-operation lasted more than one slot");

endmodule // cdsx_exec

// *** bench/test_complement_and_decrement_skip_exec.sv ***
`timescale 1ns/1ps
module test_complement_and_decrement_skip_exec;
  import cdsx_pkg::*;
  logic ref_clk;
  logic arst_n = 1'b0;
  logic [13:0] instr_word = WORD_RESET;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  cdsx_file_wr_t file_wr;
  logic file_we;
  logic [7:0] acc_q;
  cdsx_flag_t zero_flag;
  logic no_operation;
  logic [3:0] phase;
  logic [7:0] regs [128];
  logic [7:0] acc_exp = DATA_RESET;
  int fails = 0;
  int total_checks = 0;
  // ****************************************************************
  // Register file stand-in, read combinationally
  // ****************************************************************
  assign rd_data = regs[rd_addr];
  cdsx_exec u_cdsx_exec (.ref_clk(ref_clk), .arst_n(arst_n), .instr_word(instr_word),
    .rd_addr(rd_addr), .rd_data(rd_data), .file_wr(file_wr), .file_we(file_we),
    .acc_q(acc_q), .zero_flag(zero_flag), .no_operation(no_operation), .phase(phase));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic sync_q1();
    int i;
    i = 0;
    while (phase !== 4'h1 && i < 8)
    begin
      @(negedge ref_clk);
      i++;
    end
    if (phase !== 4'h1)
    begin
      fails++;
      $display("wrong value at %0t: phase never reached Q1", $time);
      complete_run();
    end
  endtask
  // ****************************************************************
  // One instruction slot; follow is offered for the next slot
  // ****************************************************************
  task automatic go(input logic [5:0] op, input logic d, input logic [6:0] a,
                    input logic [13:0] follow);
    logic [7:0] res;
    logic ours;
    logic skip;
    ours = (op == OPC_COMPLEMENT) || (op == OPC_DEC_SKIP);
    res = (op == OPC_COMPLEMENT) ? ~regs[a] : regs[a] - 8'h01;
    skip = (op == OPC_DEC_SKIP) && (res == 8'h00);
    sync_q1();
    instr_word = {op, d, a};
    repeat (2) @(negedge ref_clk);
    check(rd_addr, a);
    instr_word = follow;
    repeat (2) @(negedge ref_clk);
    if (ours && d == DEST_ACC)
      acc_exp = res;
    check(acc_q, acc_exp);
    check(file_we, ours && d == DEST_FILE);
    if (ours && d == DEST_FILE)
      check(file_wr, {a, res});
    check(zero_flag.zero_we, op == OPC_COMPLEMENT);
    if (op == OPC_COMPLEMENT)
      check(zero_flag.zero_val, res == 8'h00);
    if (ours && d == DEST_FILE)
      regs[a] = res;
    @(negedge ref_clk);
    check(no_operation, skip);
    check(file_we, 1'b0);
  endtask
  task automatic t_complement();
    regs[19] = 8'h13;
    regs[127] = 8'hff;
    go(OPC_COMPLEMENT, DEST_ACC, 7'h13, WORD_RESET);
    check(acc_q, 8'hec);
    go(OPC_COMPLEMENT, DEST_FILE, 7'h7f, WORD_RESET);
    $display("test complement done");
  endtask
  task automatic t_decrement_skip();
    regs[5] = 8'h02;
    regs[0] = 8'h00;
    go(OPC_DEC_SKIP, DEST_FILE, 7'h05, WORD_RESET);
    go(OPC_DEC_SKIP, DEST_ACC, 7'h00, WORD_RESET);
    check(acc_q, 8'hff);
    // The offered word lands in the skipped slot and must leave no trace
    go(OPC_DEC_SKIP, DEST_ACC, 7'h05, {OPC_COMPLEMENT, DEST_FILE, 7'h05});
    // Withdraw the offered word so the slot after the skip decodes nothing
    instr_word = WORD_RESET;
    repeat (3) @(negedge ref_clk);
    check(phase, 4'h1);
    check(no_operation, 1'b1);
    check(file_we, 1'b0);
    check(acc_q, 8'h00);
    @(negedge ref_clk);
    check(no_operation, 1'b0);
    $display("test decrement skip done");
  endtask
  task automatic t_reset();
    go(OPC_COMPLEMENT, DEST_ACC, 7'h13, WORD_RESET);
    arst_n = 1'b0;
    @(negedge ref_clk);
    check(phase, 4'h1);
    check(acc_q, DATA_RESET);
    check(no_operation, 1'b0);
    check(file_we, 1'b0);
    check(zero_flag, 2'b00);
    acc_exp = DATA_RESET;
    arst_n = 1'b1;
    go(OPC_COMPLEMENT, DEST_ACC, 7'h13, WORD_RESET);
    $display("test mid-run reset done");
  endtask
  task automatic t_foreign();
    go(6'h03, DEST_FILE, 7'h05, WORD_RESET);
    $display("test foreign opcode done");
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++)
      regs[i] = 8'h5a;
    repeat (3) @(negedge ref_clk);
    check(phase, 4'h1);
    check(acc_q, DATA_RESET);
    check(no_operation, 1'b0);
    check(file_we, 1'b0);
    check(zero_flag, 2'b00);
    arst_n = 1'b1;
    t_complement();
    t_decrement_skip();
    t_foreign();
    t_reset();
    complete_run();
  end
endmodule // test_complement_and_decrement_skip_exec
